// ==== logic/drive_terminal_pkg.sv ====
// shared constants, types and register map of the drive terminal block
package drive_terminal_pkg;
  // register byte offsets and terminal counts
  localparam logic [7:0] OFS_CODE0   = 8'h00; // five open-collector codes, then two relays
  localparam logic [7:0] OFS_STOPSEL = 8'h1C;
  localparam logic [7:0] OFS_CTRL    = 8'h20;
  localparam logic [7:0] OFS_INSEL0  = 8'h24; // four general input selects
  localparam logic [7:0] OFS_STATUS  = 8'h34;
  localparam int         NUM_OUT     = 7;
  localparam int         NUM_GEN     = 4;
  // values after reset
  localparam logic [15:0] RST_RELAY1  = 16'h0063;
  localparam logic [15:0] RST_RELAY2  = 16'h270F;
  localparam logic [15:0] RST_STOPSEL = 16'h270F;
  localparam logic [15:0] RST_INSEL   = 16'h0000;
  // function code and stop selection values
  localparam logic [15:0] CODE_NONE   = 16'h270F;
  localparam logic [15:0] CODE_NEG    = 16'h0064;
  localparam logic [15:0] CODE_LIMIT  = 16'h00C8;
  localparam logic [15:0] CODE_STOPIN = 16'h0019;
  localparam logic [15:0] SEL_COAST_HI = 16'h0064;
  localparam logic [15:0] SEL_SD_LO   = 16'h03E8;
  localparam logic [15:0] SEL_SD_HI   = 16'h044C;
  localparam logic [15:0] SEL_SD_DEC  = 16'h22B8;
  // timing and percentage thresholds
  localparam int          CLK_MHZ     = 100;
  localparam int          SEC_US      = 1000000;
  localparam int          SEC_CYCLES  = CLK_MHZ * SEC_US;
  localparam logic [3:0]  READY_CYCLES = 4'hF;
  localparam logic [6:0]  PCT_PRE     = 7'h55;
  localparam logic [6:0]  PCT_FULL    = 7'h64;

  // start sequencing states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_RUN   = 5'b00010,
    ST_DECEL = 5'b00100,
    ST_WAIT  = 5'b01000,
    ST_COAST = 5'b10000
  } run_state_e;

  // terminal inputs
  typedef struct packed {
    logic               fwd;
    logic               rev;
    logic               shutoff;
    logic               jog;
    logic [NUM_GEN-1:0] gen;
  } term_s;

  // measurements and conditions from the drive core
  typedef struct packed {
    logic [15:0] out_freq;
    logic [15:0] set_freq;
    logic [15:0] start_freq;
    logic [15:0] fu_level;
    logic [15:0] fu_rev_level;
    logic [15:0] fu2_level;
    logic [15:0] current;
    logic [15:0] cur_level;
    logic [15:0] cur_qual;
    logic [15:0] power;
    logic [15:0] pow_level;
    logic [15:0] pow_qual;
    logic [15:0] brake_use;
    logic [15:0] brake_limit;
    logic [15:0] thermal;
    logic [15:0] thermal_trip;
    logic        stall;
    logic        power_fail;
    logic        fault;
    logic        panel;
  } meas_s;
endpackage

// ==== logic/drive_terminal.sv ====
// start decoding, self-holding latch and status output selection of a drive
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
// What this block does
// - two-wire: one input runs, none/both stop
// - start/direction mode for 1000-1100 or 8888
// - coast modes coast when start drops
// - coast after programmed delay in seconds
// - stop input on enables self-holding triggers
// - start pulse is latched and keeps running
// - stop input off clears hold, decelerates
// - jog enabled ignores stop input
// - output shutoff keeps the start latch
// - output shutoff cuts output immediately
// - code 25 routes stop to terminal
// - codes 0-99 positive, 100-199 inverted
// - output codes reset to documented defaults
// - relays refuse codes 92 and 93
// - running flag above starting frequency
// - reached flag at set frequency
// - overload flag during stall prevention
// - frequency detect with reverse threshold
// - brake pre-alarm at 85 percent
// - thermal pre-alarm 85, trip 100 percent
// - ready flag after reset sequence
// - overcurrent flag after qualification time
// - low power flag after qualification time
module drive_terminal #(
  parameter int SEC_CYC = drive_terminal_pkg::SEC_CYCLES
) (
  // clock and reset
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_n_i,
  // ahb-lite slave
  input  wire logic                       hsel_i,
  input  wire logic [31:0]                haddr_i,
  input  wire logic [1:0]                 htrans_i,
  input  wire logic                       hwrite_i,
  input  wire logic [2:0]                 hsize_i,
  input  wire logic [31:0]                hwdata_i,
  input  wire logic                       hready_i,
  output logic      [31:0]                hrdata_o,
  output logic                            hreadyout_o,
  output logic                            hresp_o,
  // terminals and drive core
  input  wire drive_terminal_pkg::term_s  term_i,
  input  wire drive_terminal_pkg::meas_s  meas_i,
  // drive commands
  output logic                            run_o,
  output logic                            reverse_o,
  output logic                            decel_o,
  output logic                            output_cut_o,
  output logic                            thermal_trip_o,
  // status terminals
  output logic [4:0]                      oc_out_o,
  output logic [1:0]                      relay_o
);

  // map a function code onto its flag, inverted for the upper range
  function automatic logic pick_flag(input logic [15:0] code, input logic [13:0] f, input logic fault_alarm_flag);
    logic [15:0] b;
    logic        v;
    b = (code >= drive_terminal_pkg::CODE_NEG) ? code - drive_terminal_pkg::CODE_NEG : code;
    // unlisted flags (6, 9) are tied low, so a plain index covers the table
    v = (b < 16'h000E) ? f[b[3:0]] : (b == 16'h0063) && fault_alarm_flag;
    pick_flag = (code < drive_terminal_pkg::CODE_LIMIT) && ((code >= drive_terminal_pkg::CODE_NEG) ? ~v : v);
  endfunction

  // code accepted for a terminal; relays refuse the 92/93 pair
  function automatic logic code_ok(input logic [15:0] code, input logic relay);
    logic [15:0] b;
    b = (code >= drive_terminal_pkg::CODE_NEG) ? code - drive_terminal_pkg::CODE_NEG : code;
    code_ok = (code == drive_terminal_pkg::CODE_NONE) ||
              ((code < drive_terminal_pkg::CODE_LIMIT) && !(relay && (b == 16'h005C || b == 16'h005D)));
  endfunction

  // value reached a percentage of a limit
  function automatic logic pct_at(input logic [15:0] v, input logic [15:0] lim, input logic [6:0] pct);
    pct_at = ({7'h00, v} * 23'(drive_terminal_pkg::PCT_FULL)) >= ({7'h00, lim} * 23'(pct));
  endfunction

  logic [15:0]                      code [drive_terminal_pkg::NUM_OUT];
  logic [15:0]                      insel [drive_terminal_pkg::NUM_GEN];
  logic [15:0]                      stop_sel, oc_cnt, zc_cnt, delay_s;
  drive_terminal_pkg::term_s        sy1, sy2, sy3;
  drive_terminal_pkg::run_state_e   state, next_state;
  logic [31:0]                      sub_cnt, rd_mux;
  logic [6:0]                       sec_cnt;
  logic [3:0]                       por_cnt;
  logic [7:0]                       dp_addr;
  logic [13:0]                      flags;
  logic                             jog_en, held_f, held_r, hold_q, dp_act, dp_wr, stop_lvl, jog_act;
  logic                             hold_mode, sd_mode, coast_mode, lvl_f, lvl_r, cmd_run, cmd_rev;
  logic                             stopped, delay_done, ready;
  // two-flop synchroniser, third stage for edge detection
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {sy3, sy2, sy1} <= '0;
    end else begin
      {sy3, sy2, sy1} <= {sy2, sy1, term_i};
    end
  end
  // stop input found on any terminal selected for it
  always_comb begin
    stop_lvl = 1'b0;
    for (int i = 0; i < drive_terminal_pkg::NUM_GEN; i++) begin
      stop_lvl = stop_lvl | (sy2.gen[i] && insel[i] == drive_terminal_pkg::CODE_STOPIN);
    end
  end
  // mode decode from the stop input, the jog terminal and the stop selection setting
  assign jog_act    = sy2.jog && jog_en;
  assign hold_mode  = stop_lvl && !jog_act;
  assign sd_mode    = (stop_sel >= drive_terminal_pkg::SEL_SD_LO && stop_sel <= drive_terminal_pkg::SEL_SD_HI) ||
                      stop_sel == drive_terminal_pkg::SEL_SD_DEC;
  assign coast_mode = stop_sel <= drive_terminal_pkg::SEL_COAST_HI ||
                      (stop_sel >= drive_terminal_pkg::SEL_SD_LO && stop_sel <= drive_terminal_pkg::SEL_SD_HI);
  assign delay_s    = (stop_sel >= drive_terminal_pkg::SEL_SD_LO) ? stop_sel - drive_terminal_pkg::SEL_SD_LO
                                                                  : stop_sel;
  // self-holding latch; shutoff is deliberately not part of the clear
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      held_f <= 1'b0;
      held_r <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      hold_q <= hold_mode;
      if (!stop_lvl && !jog_act) begin
        held_f <= 1'b0;
        held_r <= 1'b0;
      end else if (hold_mode) begin
        if (sy2.fwd && !sy3.fwd) begin
          held_f <= 1'b1;
          if (!sd_mode) begin
            held_r <= 1'b0;
          end
        end else if (sy2.rev && !sy3.rev && !sd_mode) begin
          held_r <= 1'b1;
          held_f <= 1'b0;
        end
      end
    end
  end

  // command decode: held triggers in 3-wire, levels in 2-wire
  assign lvl_f      = hold_mode ? held_f : sy2.fwd;
  assign lvl_r      = (hold_mode && !sd_mode) ? held_r : sy2.rev;
  assign cmd_run    = sd_mode ? lvl_f : lvl_f ^ lvl_r;
  assign cmd_rev    = sd_mode ? lvl_f && lvl_r : lvl_r && !lvl_f;
  assign stopped    = meas_i.out_freq == 16'h0000;
  assign delay_done = (sec_cnt == delay_s[6:0]);
  // run sequencing
  always_comb begin
    next_state = state;
    case (state)
      drive_terminal_pkg::ST_IDLE: begin
        if (cmd_run) begin
          next_state = drive_terminal_pkg::ST_RUN;
        end
      end
      drive_terminal_pkg::ST_RUN: begin
        if (!cmd_run) begin
          // a stop-input release always decelerates, even in coast modes
          if (coast_mode && !(hold_q && !hold_mode)) begin
            next_state = drive_terminal_pkg::ST_WAIT;
          end else begin
            next_state = drive_terminal_pkg::ST_DECEL;
          end
        end
      end
      drive_terminal_pkg::ST_WAIT: begin
        if (cmd_run) begin
          next_state = drive_terminal_pkg::ST_RUN;
        end else if (delay_done) begin
          next_state = drive_terminal_pkg::ST_COAST;
        end
      end
      drive_terminal_pkg::ST_DECEL,
      drive_terminal_pkg::ST_COAST: begin
        if (cmd_run) begin
          next_state = drive_terminal_pkg::ST_RUN;
        end else if (stopped) begin
          next_state = drive_terminal_pkg::ST_IDLE;
        end
      end
      default: next_state = drive_terminal_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= drive_terminal_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end
  // coast delay timer: sub-second prescaler, then whole seconds
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sub_cnt <= '0;
      sec_cnt <= '0;
    end else if (state != drive_terminal_pkg::ST_WAIT) begin
      sub_cnt <= '0;
      sec_cnt <= '0;
    end else if (!delay_done) begin
      if (sub_cnt == 32'(SEC_CYC - 1)) begin
        sub_cnt <= '0;
        sec_cnt <= sec_cnt + 7'h01;
      end else begin
        sub_cnt <= sub_cnt + 32'h1;
      end
    end
  end
  // drive commands; shutoff forces run off and output cut, while decel and reverse still follow the sequencer
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_o          <= 1'b0;
      reverse_o      <= 1'b0;
      decel_o        <= 1'b0;
      output_cut_o   <= 1'b1;
      thermal_trip_o <= 1'b0;
    end else begin
      run_o        <= (next_state == drive_terminal_pkg::ST_RUN || next_state == drive_terminal_pkg::ST_WAIT)
                      && !sy2.shutoff;
      decel_o      <= next_state == drive_terminal_pkg::ST_DECEL;
      output_cut_o <= sy2.shutoff || next_state == drive_terminal_pkg::ST_COAST ||
                      next_state == drive_terminal_pkg::ST_IDLE;
      if (cmd_run) begin
        reverse_o <= cmd_rev;
      end
      thermal_trip_o <= pct_at(meas_i.thermal, meas_i.thermal_trip, drive_terminal_pkg::PCT_FULL);
    end
  end
  // power-on sequence and current/power qualification counters
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      por_cnt <= '0;
      oc_cnt  <= '0;
      zc_cnt  <= '0;
    end else begin
      if (por_cnt != drive_terminal_pkg::READY_CYCLES) begin
        por_cnt <= por_cnt + 4'h1;
      end
      if (meas_i.current <= meas_i.cur_level) begin
        oc_cnt <= '0;
      end else if (oc_cnt != 16'hFFFF) begin
        oc_cnt <= oc_cnt + 16'h1;
      end
      if (meas_i.power >= meas_i.pow_level) begin
        zc_cnt <= '0;
      end else if (zc_cnt != 16'hFFFF) begin
        zc_cnt <= zc_cnt + 16'h1;
      end
    end
  end
  // status flags indexed by base function code
  assign ready = por_cnt == drive_terminal_pkg::READY_CYCLES && !meas_i.fault && !sy2.shutoff;
  always_comb begin
    flags     = '0;
    flags[0]  = run_o && meas_i.out_freq >= meas_i.start_freq;
    flags[1]  = run_o && meas_i.out_freq >= meas_i.set_freq;
    flags[2]  = meas_i.power_fail;
    flags[3]  = meas_i.stall;
    flags[4]  = meas_i.out_freq >= (reverse_o ? meas_i.fu_rev_level : meas_i.fu_level);
    flags[5]  = meas_i.out_freq >= meas_i.fu2_level;
    flags[7]  = pct_at(meas_i.brake_use, meas_i.brake_limit, drive_terminal_pkg::PCT_PRE);
    flags[8]  = pct_at(meas_i.thermal, meas_i.thermal_trip, drive_terminal_pkg::PCT_PRE);
    flags[10] = meas_i.panel;
    flags[11] = ready;
    flags[12] = oc_cnt > meas_i.cur_qual;
    flags[13] = zc_cnt > meas_i.pow_qual;
  end

  // status terminals
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oc_out_o <= '0;
      relay_o  <= '0;
    end else begin
      for (int i = 0; i < 5; i++) begin
        oc_out_o[i] <= pick_flag(code[i], flags, meas_i.fault);
      end
      relay_o[0] <= pick_flag(code[5], flags, meas_i.fault);
      relay_o[1] <= pick_flag(code[6], flags, meas_i.fault);
    end
  end

  // ahb-lite: zero wait states, always okay
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // address phase capture
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dp_act  <= 1'b0;
      dp_wr   <= 1'b0;
      dp_addr <= '0;
    end else if (hready_i) begin
      dp_act  <= hsel_i && htrans_i[1];
      dp_wr   <= hwrite_i;
      dp_addr <= haddr_i[7:0];
    end
  end

  // read mux; unmapped words read as zero
  always_comb begin
    rd_mux = '0;
    for (int i = 0; i < drive_terminal_pkg::NUM_OUT; i++) begin
      if (haddr_i[7:0] == drive_terminal_pkg::OFS_CODE0 + 8'(4 * i)) begin
        rd_mux = {16'h0000, code[i]};
      end
    end
    for (int i = 0; i < drive_terminal_pkg::NUM_GEN; i++) begin
      if (haddr_i[7:0] == drive_terminal_pkg::OFS_INSEL0 + 8'(4 * i)) begin
        rd_mux = {16'h0000, insel[i]};
      end
    end
    case (haddr_i[7:0])
      drive_terminal_pkg::OFS_STOPSEL: rd_mux = {16'h0000, stop_sel};
      drive_terminal_pkg::OFS_CTRL:    rd_mux = {31'h0, jog_en};
      drive_terminal_pkg::OFS_STATUS:  rd_mux = {16'h0, held_r, held_f, hold_mode, output_cut_o, decel_o,
                                                 reverse_o, run_o, state, oc_out_o[3:0]} | {9'h0, relay_o, oc_out_o[4],
                                                 20'h0};
      default: ;
    endcase
  end

  // read data registered at the address phase, valid in the data phase
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata_o <= '0;
    end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
      hrdata_o <= rd_mux;
    end
  end

  // register writes in the data phase; refused codes leave the old value
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 5; i++) begin
        code[i] <= 16'(i);
      end
      code[5]  <= drive_terminal_pkg::RST_RELAY1;
      code[6]  <= drive_terminal_pkg::RST_RELAY2;
      for (int i = 0; i < drive_terminal_pkg::NUM_GEN; i++) begin
        insel[i] <= drive_terminal_pkg::RST_INSEL;
      end
      stop_sel <= drive_terminal_pkg::RST_STOPSEL;
      jog_en   <= 1'b0;
    end else if (dp_act && dp_wr) begin
      for (int i = 0; i < drive_terminal_pkg::NUM_OUT; i++) begin
        if (dp_addr == drive_terminal_pkg::OFS_CODE0 + 8'(4 * i) && code_ok(hwdata_i[15:0], i >= 5)) begin
          code[i] <= hwdata_i[15:0];
        end
      end
      for (int i = 0; i < drive_terminal_pkg::NUM_GEN; i++) begin
        if (dp_addr == drive_terminal_pkg::OFS_INSEL0 + 8'(4 * i)) begin
          insel[i] <= hwdata_i[15:0];
        end
      end
      if (dp_addr == drive_terminal_pkg::OFS_STOPSEL) begin
        stop_sel <= hwdata_i[15:0];
      end
      if (dp_addr == drive_terminal_pkg::OFS_CTRL) begin
        jog_en <= hwdata_i[0];
      end
    end
  end

endmodule // drive_terminal

// ==== test/drive_terminal_monitor.sv ====
// concurrent checks on the ports of the drive terminal block
`timescale 1ns/10ps
module drive_terminal_monitor (
  // clock, reset and bus
  input wire logic                      core_clk_i,
  input wire logic                      rst_n_i,
  input wire logic                      hsel_i,
  input wire logic [31:0]               haddr_i,
  input wire logic [1:0]                htrans_i,
  input wire logic                      hwrite_i,
  input wire logic                      hready_i,
  input wire logic [31:0]               hrdata_o,
  input wire logic                      hreadyout_o,
  input wire logic                      hresp_o,
  // terminals, core and commands
  input wire drive_terminal_pkg::term_s term_i,
  input wire drive_terminal_pkg::meas_s meas_i,
  input wire logic                      run_o,
  input wire logic                      decel_o,
  input wire logic                      output_cut_o,
  input wire logic                      thermal_trip_o,
  input wire logic [4:0]                oc_out_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // bus slave never stalls and never errs, so a master cannot hang on it
  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus slave stalled or answered with error");
  a_unmapped_zero: assert property (hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i >= 32'h38
    && haddr_i < 32'h100 |=> hrdata_o == 32'h0) else $error("unmapped read not zero");
  // two sync flops plus the output flop give three edges of latency
  a_shutoff_cuts: assert property (term_i.shutoff [*3] |=> output_cut_o && !run_o)
    else $error("shutoff did not cut output");
  a_run_cut_excl: assert property (!(run_o && output_cut_o))
    else $error("output cut while running");
  a_decel_no_run: assert property (decel_o |-> !run_o)
    else $error("running while decelerating");
  a_trip_level: assert property (1'b1 |=> thermal_trip_o == ($past(meas_i.thermal) >= $past(meas_i.thermal_trip)))
    else $error("thermal trip not at full level");
  // default codes kept on these two terminals for the whole run
  a_pfail_follow: assert property (1'b1 |=> oc_out_o[2] == $past(meas_i.power_fail))
    else $error("power fail terminal wrong");
  a_stall_overload: assert property (meas_i.stall ##1 meas_i.stall |-> oc_out_o[3])
    else $error("overload terminal off during stall");
endmodule // drive_terminal_monitor

bind drive_terminal drive_terminal_monitor mon_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .term_i(term_i), .meas_i(meas_i), .run_o(run_o),
  .decel_o(decel_o), .output_cut_o(output_cut_o), .thermal_trip_o(thermal_trip_o), .oc_out_o(oc_out_o));

// ==== test/drive_terminal_switches.sv ====
// switches or controller on the drive control terminals
`timescale 1ns/10ps
module drive_terminal_switches (
  // sampling clock
  input  wire logic                  clk_i,
  // terminal levels, stop contact on general terminal zero
  output drive_terminal_pkg::term_s term_o
);
  initial term_o = '0;

  // levels move just after an edge; opening the stop contact ends a held run
  task automatic set(input logic f, r, s, j, stp);
    @(posedge clk_i);
    term_o <= '{f, r, s, j, {3'h0, stp}};
  endtask

  // a start push held w cycles; the opposite push reverses a held run
  task automatic pulse(input logic r, input int w);
    @(posedge clk_i);
    if (r) term_o.rev <= 1'b1;
    else term_o.fwd <= 1'b1;
    repeat (w) @(posedge clk_i);
    term_o.rev <= 1'b0;
    term_o.fwd <= 1'b0;
  endtask
endmodule // drive_terminal_switches

// ==== test/drive_terminal_tb.sv ====
// self-checking bench of the drive terminal block
`timescale 1ns/10ps
module drive_terminal_tb;
  typedef struct {logic [43:0] m; logic [43:0] e; string nm;} note_s;
  localparam logic [11:0] RUN = 12'h001, REV = 12'h002, DEC = 12'h004, CUT = 12'h008, TRIP = 12'h010;
  localparam logic [11:0] OC0 = 12'h020, OC1 = 12'h040, OC3 = 12'h100, RL0 = 12'h400;
  localparam logic [15:0] dflt [7] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0063, 16'h270F};
  localparam logic [15:0] bad [4]  = '{16'h005C, 16'h005D, 16'h00C0, 16'h00C1};
  localparam logic [15:0] mode [2] = '{16'h270F, 16'h22B8};
  localparam logic [15:0] coast [2] = '{16'h0001, 16'h03E9};
  logic                      core_clk_i, rst_n_i, hsel, hwrite, hresp, run, rev, dec, cut, trip;
  logic [1:0]                htrans, relay;
  logic [31:0]               haddr, hwdata, hrdata;
  logic [15:0]               seed;
  logic [4:0]                oc;
  wire logic                 rdy;
  drive_terminal_pkg::term_s term;
  drive_terminal_pkg::meas_s meas;
  note_s                     q [$];
  note_s                     n;
  int                        err_count, compares;
  event                      look;
  wire logic [43:0]          obs = {hrdata, relay, oc, trip, cut, dec, rev, run};

  drive_terminal #(.SEC_CYC(10)) drive_terminal_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(rdy),
    .hrdata_o(hrdata), .hreadyout_o(rdy), .hresp_o(hresp), .term_i(term), .meas_i(meas), .run_o(run),
    .reverse_o(rev), .decel_o(dec), .output_cut_o(cut), .thermal_trip_o(trip), .oc_out_o(oc), .relay_o(relay));
  drive_terminal_switches sw (.clk_i(core_clk_i), .term_o(term));

  // 100 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // oldest note against what the outputs show now
  initial forever begin
    @(look);
    n = q.pop_front();
    compares++;
    if ((obs & n.m) !== n.e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n.nm, n.e, obs & n.m);
    end
  end

  task automatic summarize();
    if (err_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // two-wire: exactly one input runs; start/direction: fwd runs, rev picks direction
  function automatic logic [11:0] exp2(input int m, input logic f, r);
    return ((m == 0) ? (f ^ r) : f) ? {10'h0, r, 1'b1} : 12'h0;
  endfunction

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk_i);
  endtask

  task automatic note(input logic [43:0] m, e, input string nm);
    q.push_back('{m, e, nm});
    -> look;
  endtask

  // outputs settle one step after the edge
  task automatic chk(input logic [11:0] m, e, input string nm);
    #1;
    note({32'h0, m}, {32'h0, e}, nm);
  endtask

  // bounded wait for hready, a lost slave ends the run
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (rdy !== 1'b1 && k < 40);
    if (k >= 40) begin
      err_count++;
      summarize();
    end
  endtask

  // single word transfer; a read compares its data at the data edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input string nm);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    wait_rdy();
    if (!wr) note({32'hFFFFFFFF, 12'h0}, {d, 12'h0}, nm);
  endtask

  // status code on open collector one, then its level
  task automatic flag(input logic [15:0] code, input logic v);
    bus(1'b1, 8'h04, {16'h0, code}, "");
    cyc(6);
    chk(OC1, v ? OC1 : 12'h0, "status flag");
  endtask

  initial begin
    logic [11:0] e;
    {rst_n_i, hsel, hwrite, htrans, haddr, hwdata} = '0;
    meas = '0;
    seed = 16'hC132;
    err_count = 0;
    compares = 0;
    cyc(6);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 7; i++) bus(1'b0, 8'(4 * i), {16'h0, dflt[i]}, "code reset");
    bus(1'b0, 8'h40, 32'h0, "unmapped");
    foreach (bad[i]) begin
      bus(1'b1, 8'h14, {16'h0, bad[i]}, "");
      bus(1'b0, 8'h14, 32'h63, "relay refuse");
    end
    bus(1'b1, 8'h18, 32'h5E, "");
    bus(1'b0, 8'h18, 32'h5E, "relay accept");
    repeat (3) begin
      seed = lfsr(seed);
      bus(1'b1, 8'h04, {17'h1, seed[14:0]}, "");
      bus(1'b0, 8'h04, 32'h1, "refused code");
    end
    // every input combination in both decode modes, stopping in between
    foreach (mode[m]) begin
      bus(1'b1, 8'h1C, {16'h0, mode[m]}, "");
      for (int c = 0; c < 4; c++) begin
        sw.set(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        cyc(4);
        sw.set(c[1], c[0], 1'b0, 1'b0, 1'b0);
        cyc(6);
        e = exp2(m, c[1], c[0]);
        chk(e[0] ? RUN | REV : RUN, e, "start decode");
      end
    end
    // one second delay is ten cycles here, for both setting ranges
    foreach (coast[k]) begin
      bus(1'b1, 8'h1C, {16'h0, coast[k]}, "");
      sw.set(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      cyc(6);
      sw.set(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
      cyc(5);
      chk(RUN | CUT, RUN, "coast wait");
      cyc(15);
      chk(RUN | CUT, CUT, "coast cut");
    end
    // stop contact on a general terminal gives self-holding
    bus(1'b1, 8'h1C, 32'h270F, "");
    bus(1'b1, 8'h24, 32'h19, "");
    sw.set(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    sw.pulse(1'b0, 2);
    cyc(6);
    chk(RUN | REV | OC0, RUN | OC0, "held fwd");
    sw.pulse(1'b1, 1);
    cyc(6);
    chk(RUN | REV, RUN | REV, "held rev");
    sw.set(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    cyc(5);
    chk(RUN | CUT, CUT, "shutoff");
    sw.set(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    cyc(5);
    chk(RUN | REV, RUN | REV, "hold kept");
    meas.out_freq <= 16'h0100;
    sw.set(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    cyc(5);
    chk(RUN | DEC, DEC, "stop release");
    meas.out_freq <= 16'h0000;
    bus(1'b1, 8'h20, 32'h1, "");
    sw.set(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    cyc(6);
    chk(RUN, RUN, "jog");
    sw.set(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    cyc(5);
    chk(RUN, 12'h0, "jog stop ignored");
    // status flags at their exact thresholds
    meas.thermal_trip <= 16'h0064;
    meas.thermal <= 16'h0055;
    flag(16'h0008, 1'b1);
    flag(16'h006C, 1'b0);
    meas.thermal <= 16'h0054;
    flag(16'h0008, 1'b0);
    meas.thermal <= 16'h0064;
    cyc(2);
    chk(TRIP, TRIP, "thermal trip");
    seed = lfsr(seed);
    meas.cur_level <= {4'h0, seed[11:0]};
    meas.current <= {4'h0, seed[11:0]} + 16'h0001;
    meas.cur_qual <= 16'h0003;
    flag(16'h000C, 1'b1);
    meas.current <= {4'h0, seed[11:0]};
    flag(16'h000C, 1'b0);
    meas.pow_level <= {4'h0, seed[11:0]} + 16'h0001;
    meas.power <= {4'h0, seed[11:0]};
    meas.pow_qual <= 16'h0003;
    flag(16'h0071, 1'b0);
    flag(16'h000B, 1'b1);
    meas.fault <= 1'b1;
    meas.stall <= 1'b1;
    meas.power_fail <= 1'b1;
    flag(16'h006F, 1'b1);
    chk(RL0 | OC3, RL0 | OC3, "fault and overload");
    cyc(2);
    summarize();
  end
endmodule // drive_terminal_tb
